// >>> core/hpl_pkg.sv
/*
  Constants and types shared by the host port and loopback pin front end.
  Assumes a single 50 MHz clock and a classic Wishbone register slave.
*/
package hpl_pkg;

  // ----------------------------------------------------------------
  // Pin widths and synchroniser bit layout
  // ----------------------------------------------------------------
  localparam int DW     = 8;
  localparam int AW     = 8;
  localparam int EQC_W  = 5;
  localparam int NCH    = 8;
  localparam int LB_W   = 2;
  localparam int SB_MODE = 0;
  localparam int SB_SER  = 1;
  localparam int SB_PT   = 2;
  localparam int SB_WR   = 4;
  localparam int SB_RD   = 5;
  localparam int SB_ALE  = 6;
  localparam int SB_CS   = 7;
  localparam int SB_RDY  = 8;
  localparam int SB_D    = 9;
  localparam int SB_A    = 17;
  localparam int SYNC_W  = 25;
  // The mode pin idles high, so its synchroniser starts in hardware mode.
  localparam logic [SYNC_W-1:0] SYNC_RST = 25'h0000001;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PT_INTEL   = 2'h0;
  localparam logic [1:0] PT_MOTO    = 2'h1;
  localparam logic [1:0] PT_SYNC    = 2'h3;
  localparam logic [1:0] LB_NONE    = 2'h0;
  localparam logic [1:0] LB_ANALOG  = 2'h1;
  localparam logic [1:0] LB_REMOTE  = 2'h2;
  localparam logic [1:0] LB_DIGITAL = 2'h3;

  // ----------------------------------------------------------------
  // Wishbone register map
  // ----------------------------------------------------------------
  localparam int         WB_AW    = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_LOOP = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h40;
  localparam int         BANK_N   = 16;
  localparam int         BANK_IW  = 4;
  localparam int         DLY_W    = 4;
  localparam logic [3:0] RDY_DLY_RST = 4'h2;
  localparam int ST_HOST = 0;
  localparam int ST_SER  = 1;
  localparam int ST_PT   = 2;
  localparam int ST_EQC  = 8;
  localparam int ST_ADR  = 16;
  localparam int ST_BUSY = 24;

  typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_ACK} hpl_hst_t;

endpackage : hpl_pkg

// >>> core/hpl_sync.sv
/*
  Three-stage pin synchroniser with agreement filter, one lane per bit.
  Assumes inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ps
module hpl_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] q_o
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r, s2_r, s3_r;
      // The first stage feeds only the second.
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          s1_r   <= RST[i];
          s2_r   <= RST[i];
          s3_r   <= RST[i];
          q_o[i] <= RST[i];
        end else begin
          s1_r <= pin_i[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            q_o[i] <= s3_r;
          end
        end
      end
    end
  endgenerate
endmodule : hpl_sync

// >>> core/hpl_loop_dec.sv
/*
  Maps data and address pins to per-channel loopback selects and decodes them.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
module hpl_loop_dec (
  input  wire logic [hpl_pkg::DW-1:0]            data_i,
  input  wire logic [hpl_pkg::AW-1:0]            addr_i,
  output logic      [hpl_pkg::NCH*hpl_pkg::LB_W-1:0] sel_o,
  output logic      [hpl_pkg::NCH-1:0]           analog_o,
  output logic      [hpl_pkg::NCH-1:0]           remote_o,
  output logic      [hpl_pkg::NCH-1:0]           digital_o
);
  import hpl_pkg::*;
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      if (c < 4) begin : g_adr
        assign sel_o[2*c+1:2*c] = addr_i[2*c+1:2*c];
      end else begin : g_dat
        assign sel_o[2*c+1:2*c] = data_i[15-2*c:14-2*c];
      end
      assign analog_o[c]  = (sel_o[2*c+1:2*c] == LB_ANALOG);
      assign remote_o[c]  = (sel_o[2*c+1:2*c] == LB_REMOTE);
      assign digital_o[c] = (sel_o[2*c+1:2*c] == LB_DIGITAL);
    end
  endgenerate
endmodule : hpl_loop_dec

// >>> core/hpl_top.sv
/*
  Shared-pin front end: parallel or serial host port, or hardware pin configuration.
  Assumes all pins are asynchronous to clk_i and Wishbone runs on clk_i.
*/
`timescale 1ns/1ps
module hpl_top (
  input  wire logic                             clk_i,
  input  wire logic                             reset_i,
  input  wire logic                             host_or_pin_config_select_i,
  input  wire logic                             serial_parallel_select_i,
  input  wire logic [1:0]                       processor_type_select_i,
  input  wire logic                             write_rw_strobe_i,
  input  wire logic                             read_or_data_strobe_i,
  input  wire logic                             addr_latch_i,
  input  wire logic                             chip_select_n_i,
  input  wire logic                             ready_pin_i,
  output logic                                  ready_pin_o,
  output logic                                  ready_pin_oe_o,
  input  wire logic [hpl_pkg::DW-1:0]           data_pin_i,
  output logic      [hpl_pkg::DW-1:0]           data_pin_o,
  output logic                                  data_pin_oe_o,
  input  wire logic [hpl_pkg::AW-1:0]           addr_pin_i,
  output logic                                  host_mode_o,
  output logic      [hpl_pkg::EQC_W-1:0]        equalizer_control_pins_o,
  output logic      [hpl_pkg::NCH*hpl_pkg::LB_W-1:0] loop_sel_o,
  output logic      [hpl_pkg::NCH-1:0]          loop_analog_o,
  output logic      [hpl_pkg::NCH-1:0]          loop_remote_o,
  output logic      [hpl_pkg::NCH-1:0]          loop_digital_o,
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [hpl_pkg::WB_AW-1:0]        wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [31:0]                      wb_dat_i,
  output logic      [31:0]                      wb_dat_o,
  output logic                                  wb_ack_o
);
  import hpl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] syn;
  hpl_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   ({addr_pin_i, data_pin_i, ready_pin_i, chip_select_n_i,
               addr_latch_i, read_or_data_strobe_i, write_rw_strobe_i,
               processor_type_select_i, serial_parallel_select_i,
               host_or_pin_config_select_i}),
    .q_o     (syn)
  );

  logic          host_s, ser_s, wr_s, rd_s, cs_n_s;
  logic [1:0]    pt_s;
  logic [DW-1:0] d_s;
  logic [AW-1:0] a_s;
  logic [EQC_W-1:0] eqc_s;
  assign host_s = ~syn[SB_MODE];
  assign ser_s  = syn[SB_SER];
  assign pt_s   = syn[SB_PT+1:SB_PT];
  assign wr_s   = syn[SB_WR];
  assign rd_s   = syn[SB_RD];
  assign cs_n_s = syn[SB_CS];
  assign d_s    = syn[SB_D+DW-1:SB_D];
  assign a_s    = syn[SB_A+AW-1:SB_A];
  assign eqc_s  = syn[SB_RDY:SB_WR];

  // ----------------------------------------------------------------
  // Host strobe decode
  // ----------------------------------------------------------------
  // The synchronous type is sampled on clk_i like the strobe type; the host
  // bus clock only has to be slow enough for the three-stage filter.
  logic rd_req, wr_req, strb, selected;
  always_comb begin
    selected = host_s & ~cs_n_s;
    strb     = selected & ~rd_s;
    rd_req   = 1'b0;
    wr_req   = 1'b0;
    unique case (pt_s)
      PT_INTEL: begin
        rd_req = strb;
        wr_req = selected & ~wr_s & rd_s;
      end
      PT_MOTO, PT_SYNC: begin
        rd_req = strb & wr_s;
        wr_req = strb & ~wr_s;
      end
      default: begin
        rd_req = 1'b0;
        wr_req = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Address latch and register bank
  // ----------------------------------------------------------------
  logic [AW-1:0]    a_lat_r;
  logic [DW-1:0]    bank_r [BANK_N];
  logic [DLY_W-1:0] dly_r;
  logic             is_rd_r;
  hpl_hst_t         st_r;
  logic [DLY_W-1:0] cnt_r;
  logic             done, in_bank, wr_go, wb_go, wb_bank;
  logic [BANK_IW-1:0] wb_idx;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      a_lat_r <= '0;
    end else if (host_s && syn[SB_ALE]) begin
      a_lat_r <= a_s;
    end
  end

  assign in_bank = (a_lat_r[AW-1:BANK_IW] == '0);
  assign done    = (st_r == HS_WAIT) && (cnt_r == dly_r);
  assign wr_go   = done && !is_rd_r && !ser_s && in_bank;
  assign wb_go   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_bank = (wb_adr_i[WB_AW-1:BANK_IW+2] == OFS_BANK[WB_AW-1:BANK_IW+2]);
  assign wb_idx  = wb_adr_i[BANK_IW+1:2];

  // The host port wins a same-cycle write to one entry.
  genvar g;
  generate
    for (g = 0; g < BANK_N; g++) begin : g_bank
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          bank_r[g] <= '0;
        end else if (wr_go && a_lat_r[BANK_IW-1:0] == g) begin
          bank_r[g] <= d_s;
        end else if (wb_go && wb_we_i && wb_sel_i[0] && wb_bank && wb_idx == g) begin
          bank_r[g] <= wb_dat_i[DW-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Host access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r    <= HS_IDLE;
      cnt_r   <= '0;
      is_rd_r <= 1'b0;
    end else if (!host_s) begin
      st_r <= HS_IDLE;
    end else begin
      unique case (st_r)
        HS_IDLE: begin
          cnt_r <= '0;
          if (rd_req || wr_req) begin
            st_r    <= HS_WAIT;
            is_rd_r <= rd_req;
          end
        end
        HS_WAIT: begin
          cnt_r <= cnt_r + 1'b1;
          if (done) begin
            st_r <= HS_ACK;
          end
        end
        HS_ACK: begin
          if (!rd_req && !wr_req) begin
            st_r <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Ready pin and data bus drive
  // ----------------------------------------------------------------
  logic [DW-1:0] sh_r;
  logic          rd_s_d_r;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sh_r     <= '0;
      rd_s_d_r <= 1'b1;
    end else begin
      rd_s_d_r <= rd_s;
      if (host_s && syn[SB_ALE]) begin
        sh_r <= in_bank ? bank_r[a_lat_r[BANK_IW-1:0]] : '0;
      end else if (selected && ser_s && rd_s_d_r && !rd_s) begin
        sh_r <= {sh_r[DW-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_pin_o    <= 1'b0;
      ready_pin_oe_o <= 1'b0;
      data_pin_o     <= '0;
      data_pin_oe_o  <= 1'b0;
    end else begin
      ready_pin_oe_o <= host_s;
      ready_pin_o    <= ser_s ? sh_r[DW-1] : (host_s && st_r == HS_ACK);
      data_pin_oe_o  <= host_s && !ser_s && selected && st_r == HS_ACK && is_rd_r;
      if (done && is_rd_r) begin
        data_pin_o <= in_bank ? bank_r[a_lat_r[BANK_IW-1:0]] : '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Hardware mode pin configuration
  // ----------------------------------------------------------------
  logic [NCH*LB_W-1:0] sel_c;
  logic [NCH-1:0]      an_c, rem_c, dig_c;
  hpl_loop_dec u_dec (
    .data_i    (d_s),
    .addr_i    (a_s),
    .sel_o     (sel_c),
    .analog_o  (an_c),
    .remote_o  (rem_c),
    .digital_o (dig_c)
  );

  // In host mode these pins carry bus traffic, so loopback falls back to none.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_mode_o              <= 1'b0;
      equalizer_control_pins_o <= '0;
      loop_sel_o               <= '0;
      loop_analog_o            <= '0;
      loop_remote_o            <= '0;
      loop_digital_o           <= '0;
    end else begin
      host_mode_o <= host_s;
      if (!host_s) begin
        equalizer_control_pins_o <= eqc_s;
      end
      loop_sel_o     <= host_s ? '0 : sel_c;
      loop_analog_o  <= host_s ? '0 : an_c;
      loop_remote_o  <= host_s ? '0 : rem_c;
      loop_digital_o <= host_s ? '0 : dig_c;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dly_r <= RDY_DLY_RST;
    end else if (wb_go && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CTRL) begin
      dly_r <= wb_dat_i[DLY_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_go;
      if (wb_go) begin
        wb_dat_o <= '0;
        if (wb_adr_i == OFS_CTRL) begin
          wb_dat_o[DLY_W-1:0] <= dly_r;
        end else if (wb_adr_i == OFS_STAT) begin
          wb_dat_o[ST_HOST]            <= host_s;
          wb_dat_o[ST_SER]             <= ser_s;
          wb_dat_o[ST_PT+1:ST_PT]      <= pt_s;
          wb_dat_o[ST_EQC+EQC_W-1:ST_EQC] <= equalizer_control_pins_o;
          wb_dat_o[ST_ADR+AW-1:ST_ADR] <= a_lat_r;
          wb_dat_o[ST_BUSY]            <= (st_r != HS_IDLE);
        end else if (wb_adr_i == OFS_LOOP) begin
          wb_dat_o[NCH*LB_W-1:0] <= loop_sel_o;
        end else if (wb_bank) begin
          wb_dat_o[DW-1:0] <= bank_r[wb_idx];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_hw_no_drive: assert property (!host_s |=> !data_pin_oe_o && !ready_pin_oe_o)
    else $error("pins driven in hardware mode");
  a_cs_gates_strobe: assert property (st_r == HS_IDLE && cs_n_s |=> st_r == HS_IDLE)
    else $error("access started without chip select");
  a_rdy_completes: assert property (host_s && !ser_s && done |=> ##1 ready_pin_o)
    else $error("ready not given after access");
  a_rd_intel_dir: assert property (rd_req && pt_s == PT_INTEL |-> !rd_s && !cs_n_s)
    else $error("intel read decoded without strobe");
  a_addr_capture: assert property (host_s && syn[SB_ALE] |=> a_lat_r == $past(a_s))
    else $error("address not latched");
  a_dbus_read_only: assert property (data_pin_oe_o |-> $past(is_rd_r) && $past(host_s))
    else $error("data bus driven outside read");
  a_serial_ready: assert property (host_s && ser_s |=> ready_pin_o == $past(sh_r[DW-1]))
    else $error("serial readback wrong");
  a_eqc_take: assert property (!host_s |=> equalizer_control_pins_o == $past(eqc_s))
    else $error("equalizer pins not taken");
  a_loop_map: assert property (!host_s |=> loop_sel_o[1:0] == $past(a_s[1:0])
    && loop_sel_o[9:8] == $past(d_s[7:6]))
    else $error("loopback pin mapping wrong");
  a_loop_code: assert property (loop_digital_o[0] == (loop_sel_o[1:0] == LB_DIGITAL)
    && loop_remote_o[3] == (loop_sel_o[7:6] == LB_REMOTE))
    else $error("loopback decode wrong");
  a_host_write: assert property (wr_go |=> bank_r[a_lat_r[BANK_IW-1:0]] == $past(d_s))
    else $error("host write lost");

  c_host_read:  cover property (st_r == HS_ACK && is_rd_r ##1 data_pin_oe_o);
  c_host_write: cover property (wr_go);
  c_hw_digital: cover property (!host_s && loop_digital_o != 0);
  c_serial:     cover property (host_s && ser_s && rd_req);

endmodule : hpl_top

// >>> verification/hpl_host_model.sv
/*
  Local processor model: straps the shared pins or runs host bus cycles on them.
  Assumes the bench resolves the data and ready wires from all drivers.
*/
`timescale 1ns/1ps
module hpl_host_model (
  input  wire logic       clk_i,
  input  wire logic       rdy_i,
  input  wire logic [7:0] dev_d_i,
  input  wire logic       dev_oe_i,
  output logic            mode_o,
  output logic            ser_o,
  output logic [1:0]      pt_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic            ale_o,
  output logic            cs_n_o,
  output logic            rdy_o,
  output logic [7:0]      a_o,
  output logic [7:0]      d_o,
  output logic            d_oe_o
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  initial begin
    {mode_o, ser_o, pt_o} = 4'h8;
    {wr_o, rd_o, ale_o, cs_n_o, rdy_o} = 5'h1B;
    a_o = 8'h00;
    d_o = 8'h00;
    d_oe_o = 1'b0;
  end

  task automatic cfg(input logic m, input logic s, input logic [1:0] p);
    @(posedge clk_i);
    mode_o <= m;
    ser_o <= s;
    pt_o <= p;
    {wr_o, rd_o, cs_n_o} <= 3'h7;
    d_oe_o <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask : cfg

  task automatic straps(input logic [7:0] a, input logic [7:0] d, input logic [4:0] e);
    @(posedge clk_i);
    a_o <= a;
    d_o <= d;
    d_oe_o <= 1'b1;
    {rdy_o, cs_n_o, ale_o, rd_o, wr_o} <= e;
    repeat (10) @(posedge clk_i);
  endtask : straps

  task automatic latch(input logic [7:0] a);
    @(posedge clk_i);
    a_o <= a;
    ale_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    ale_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : latch

  // Holds strobes, select and data until ready is seen, then waits for it to drop.
  // A synchronous host runs its cycles from clk_i, which stands in for its bus clock.
  task automatic access(input logic rd, input logic sel, input logic [7:0] a,
                        input logic [7:0] w, output logic [7:0] r, output logic ok);
    int n;
    latch(a);
    d_o <= w;
    d_oe_o <= !rd;
    cs_n_o <= !sel;
    if (pt_o == 2'h0) begin
      rd_o <= !rd;
      wr_o <= rd;
    end else begin
      wr_o <= rd;
      rd_o <= 1'b0;
    end
    ok = 1'b0;
    n = 0;
    r = 8'h00;
    while (!ok && n < 60) begin
      @(posedge clk_i);
      n++;
      ok = (rdy_i === 1'b1);
    end
    if (dev_oe_i === 1'b1) r = dev_d_i;
    {wr_o, rd_o, cs_n_o, d_oe_o} <= 4'hE;
    while (rdy_i !== 1'b0 && n < 120) begin
      @(posedge clk_i);
      n++;
    end
  endtask : access

  task automatic shift_pulse;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : shift_pulse
endmodule : hpl_host_model

// >>> verification/tb.sv
/*
  Self-checking bench for the shared-pin front end.
  Assumes a 50 MHz clock and the host model for all pin traffic.
*/
`timescale 1ns/1ps
module tb;
  import hpl_pkg::*;
  logic        clk_i, reset_i, mode, ser, wr, rd, ale, cs_n, rdy_h, d_oe_h;
  logic        rdy_dev, rdy_oe, d_oe_dev, host_mode, rdy_bus, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [1:0]  pt;
  logic [4:0]  equalizer_control_pins;
  logic [7:0]  a_h, d_h, d_dev, d_bus, lan, lre, ldi, wb_adr, hd;
  logic [15:0] lsel;
  logic [31:0] wb_wdat, wb_rdat, r;
  logic        ok;
  int          fail_count, num_checks, cyc_cnt;

  assign rdy_bus = rdy_oe ? rdy_dev : rdy_h;
  // The data pins carry pull-downs, so an undriven bus reads low.
  assign d_bus = d_oe_dev ? d_dev : (d_oe_h ? d_h : 8'h00);

  hpl_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .host_or_pin_config_select_i(mode),
    .serial_parallel_select_i(ser), .processor_type_select_i(pt), .write_rw_strobe_i(wr),
    .read_or_data_strobe_i(rd), .addr_latch_i(ale), .chip_select_n_i(cs_n),
    .ready_pin_i(rdy_bus), .ready_pin_o(rdy_dev), .ready_pin_oe_o(rdy_oe),
    .data_pin_i(d_bus), .data_pin_o(d_dev), .data_pin_oe_o(d_oe_dev), .addr_pin_i(a_h),
    .host_mode_o(host_mode), .equalizer_control_pins_o(equalizer_control_pins), .loop_sel_o(lsel),
    .loop_analog_o(lan), .loop_remote_o(lre), .loop_digital_o(ldi), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));

  hpl_host_model host_u (.clk_i(clk_i), .rdy_i(rdy_bus), .dev_d_i(d_dev), .dev_oe_i(d_oe_dev),
    .mode_o(mode), .ser_o(ser), .pt_o(pt), .wr_o(wr), .rd_o(rd), .ale_o(ale),
    .cs_n_o(cs_n), .rdy_o(rdy_h), .a_o(a_h), .d_o(d_h), .d_oe_o(d_oe_h));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rdat);
    int n;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we} <= {2'h3, we};
    wb_adr <= adr;
    wb_wdat <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rdat = wb_rdat;
    {wb_cyc, wb_stb} <= 2'h0;
    chk("wb ack", 32'h1, {31'h0, wb_ack});
  endtask : wb

  task automatic wbchk(input string nm, input logic [7:0] adr, input logic [31:0] m,
                       input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, adr, 32'h0, v);
    chk(nm, exp, v & m);
  endtask : wbchk

  task automatic hw(input logic [7:0] a, input logic [7:0] d, input logic [4:0] e);
    logic [15:0] s;
    logic [7:0]  an, re, di;
    host_u.straps(a, d, e);
    for (int c = 0; c < 4; c++) begin
      s[2*c+:2] = a[2*c+:2];
      s[2*c+8+:2] = d[2*(3-c)+:2];
    end
    for (int c = 0; c < 8; c++) begin
      an[c] = (s[2*c+:2] == 2'h1);
      re[c] = (s[2*c+:2] == 2'h2);
      di[c] = (s[2*c+:2] == 2'h3);
    end
    chk("loop_sel", {16'h0, s}, {16'h0, lsel});
    chk("analog", {24'h0, an}, {24'h0, lan});
    chk("remote", {24'h0, re}, {24'h0, lre});
    chk("digital", {24'h0, di}, {24'h0, ldi});
    chk("eqc", {27'h0, e}, {27'h0, equalizer_control_pins});
    chk("data oe", 32'h0, {31'h0, d_oe_dev});
    wbchk("loop reg", OFS_LOOP, 32'hFFFF, {16'h0, s});
    wbchk("status", OFS_STAT, 32'h1F01, {19'h0, e, 8'h00});
  endtask : hw

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Clock, timeout and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 10000) begin
      fail_count++;
      end_of_test;
    end
  end

  initial begin
    logic [1:0] pts [3];
    pts = '{PT_INTEL, PT_MOTO, PT_SYNC};
    {reset_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = {4'h8, 8'h00, 32'h0};
    {fail_count, num_checks, cyc_cnt} = '0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("host mode", 32'h0, {31'h0, host_mode});
    wbchk("ctrl", OFS_CTRL, 32'hF, {28'h0, RDY_DLY_RST});
    hw(8'h1B, 8'hE4, 5'h15);
    hw(8'hE4, 8'h1B, 5'h0A);
    $display("test hardware pins done");
    wbchk("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h3, r);
    wbchk("ctrl", OFS_CTRL, 32'hF, 32'h3);
    wb(1'b1, OFS_BANK + 8'h14, 32'h3C, r);
    $display("test register bus done");
    host_u.cfg(1'b0, 1'b0, PT_INTEL);
    chk("host mode", 32'h1, {31'h0, host_mode});
    chk("loop in host", 32'h0, {16'h0, lsel});
    chk("ready oe", 32'h1, {31'h0, rdy_oe});
    host_u.access(1'b1, 1'b0, 8'h05, 8'h00, hd, ok);
    chk("no select ready", 32'h0, {31'h0, ok});
    for (int i = 0; i < 3; i++) begin
      host_u.cfg(1'b0, 1'b0, pts[i]);
      host_u.access(1'b0, 1'b1, 8'(i + 1), 8'hA0 + 8'(i), hd, ok);
      chk("write ready", 32'h1, {31'h0, ok});
      host_u.access(1'b1, 1'b1, 8'(i + 1), 8'h00, hd, ok);
      chk("read ready", 32'h1, {31'h0, ok});
      chk("host read", 32'hA0 + i, {24'h0, hd});
      chk("data oe idle", 32'h0, {31'h0, d_oe_dev});
      wbchk("bank", OFS_BANK + 8'(4 * (i + 1)), 32'hFF, 32'hA0 + i);
    end
    host_u.access(1'b1, 1'b1, 8'h05, 8'h00, hd, ok);
    chk("read ready", 32'h1, {31'h0, ok});
    chk("host read", 32'h3C, {24'h0, hd});
    host_u.access(1'b1, 1'b1, 8'h10, 8'h00, hd, ok);
    chk("read ready", 32'h1, {31'h0, ok});
    chk("host read", 32'h0, {24'h0, hd});
    $display("test parallel host port done");
    host_u.cfg(1'b0, 1'b1, PT_INTEL);
    host_u.latch(8'h05);
    for (int b = 7; b > 3; b--) begin
      chk("serial bit", 32'((8'h3C >> b) & 8'h1), {31'h0, rdy_dev});
      host_u.shift_pulse();
    end
    host_u.cfg(1'b1, 1'b0, PT_INTEL);
    chk("host mode", 32'h0, {31'h0, host_mode});
    $display("test serial and mode return done");
    end_of_test;
  end
endmodule : tb
